// *** verilog/wdog_pkg.sv ***
package wdog_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 24;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTL = 12'h0FF0;
    localparam logic [11:0] IDX_UPPER = 12'h0FF1;
    localparam logic [11:0] IDX_HIGH = 12'h0FF2;
    localparam logic [11:0] IDX_LOW = 12'h0FF3;
    localparam logic [11:0] IDX_OPT = 12'h0FF4;

    // ==========================================================
    // Status bit positions in the control/status byte
    localparam int ST_POR = 7;
    localparam int ST_STOP = 6;
    localparam int ST_WDT = 5;
    localparam int ST_EXT = 4;

    // Option register bit positions
    localparam int OPT_AO = 0;
    localparam int OPT_RES = 1;
    localparam int OPT_STOPOFF = 2;
    localparam int OPT_RUN = 3;

    // ==========================================================
    // Counter values and unlock codes
    localparam logic [23:0] RELOAD_RST = 24'hFF_FFFF;
    localparam logic [23:0] CNT_MAX = 24'hFF_FFFF;
    localparam logic [23:0] CNT_ONE = 24'h00_0001;
    localparam logic [23:0] CNT_ZERO = 24'h00_0000;
    localparam logic [23:0] REFRESH_FLOOR = 24'h00_0002;
    localparam logic [7:0] UNLOCK_1 = 8'h55;
    localparam logic [7:0] UNLOCK_2 = 8'hAA;
    localparam logic [7:0] STOP_OFF_CODE = 8'h81;
    localparam logic [7:0] STOP_ON_CODE = 8'h00;

    // Unlock sequencer states, Gray coded along the path
    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_GOT1 = 3'b001,
        LK_OPEN = 3'b011,
        LK_UPPER = 3'b010,
        LK_HIGH = 3'b110
    } lock_state_e;

    // Word address match
    function automatic logic addr_hit(input logic [13:0] a,
                                      input logic [11:0] idx);
        addr_hit = (a == {idx, 2'b00});
    endfunction

endpackage

// *** verilog/wdog_tick.sv ***
// Brings the RC oscillator into pclk and marks its rising edges
module wdog_tick
    import wdog_pkg::*;
(
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Oscillator
    input wire logic rc_clk,
    output logic tick
);

    // ==========================================================
    // Two-stage synchroniser and edge history
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Shift chain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= rc_clk;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // One pulse per oscillator period
    assign tick = sync_q & ~last_q;

endmodule

// *** verilog/wdog_unlock.sv ***
// Write-unlock sequencer for reload bytes and STOP behaviour
module wdog_unlock
    import wdog_pkg::*;
(
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Completed bus writes
    input wire logic wr_any,
    input wire logic wr_ctl,
    input wire logic wr_upper,
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [7:0] wdata,
    // Results
    output logic ld_upper,
    output logic ld_high,
    output logic ld_low,
    output logic stop_off_q
);

    // ==========================================================
    // State
    lock_state_e state_q;
    lock_state_e state_d;
    logic stop_off_d;

    // Reload byte strobes only in their turn
    assign ld_upper = wr_upper && state_q == LK_OPEN;
    assign ld_high = wr_high && state_q == LK_UPPER;
    assign ld_low = wr_low && state_q == LK_HIGH;

    // Next state; any write outside the sequence relocks
    always_comb
    begin
        state_d = state_q;
        stop_off_d = stop_off_q;
        if (wr_any)
        begin
            state_d = LK_IDLE;
            unique case (state_q)
                LK_IDLE:
                    if (wr_ctl && wdata == UNLOCK_1)
                        state_d = LK_GOT1;
                LK_GOT1:
                    if (wr_ctl && wdata == UNLOCK_2)
                        state_d = LK_OPEN;
                LK_OPEN:
                begin
                    if (ld_upper)
                        state_d = LK_UPPER;
                    if (wr_ctl && wdata == STOP_OFF_CODE)
                        stop_off_d = 1'b1;
                    if (wr_ctl && wdata == STOP_ON_CODE)
                        stop_off_d = 1'b0;
                end
                LK_UPPER:
                    if (ld_high)
                        state_d = LK_HIGH;
                LK_HIGH:
                    state_d = LK_IDLE;
                default:
                    state_d = LK_IDLE;
            endcase
        end
    end

    // State registers; watchdog runs in STOP by default
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= LK_IDLE;
            stop_off_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            stop_off_q <= stop_off_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    stray_relock_a: assert property (
        wr_any && !ld_upper && !ld_high && state_q != LK_IDLE
        && !(state_q == LK_GOT1 && wr_ctl && wdata == UNLOCK_2)
        |=> state_q == LK_IDLE)
        else $error("stray write did not relock");

    stop_code_a: assert property (
        wr_ctl && state_q == LK_OPEN && wdata == STOP_OFF_CODE
        |=> stop_off_q && state_q == LK_IDLE)
        else $error("stop disable code not taken");

endmodule

// *** verilog/wdog_core.sv ***
// Notes on behaviour
// - Counter advances only on RC oscillator edges
// - Two states only: off, or on counting
// - Enabled by refresh instruction or always-on option
// - 24-bit down-counter; reload bytes upper, high, low
// - Period equals reload in oscillator counts
// - Refresh ignored at count two or below
// - First enable loads reload, then counts down
// - Each refresh above count two reloads counter from reload bytes
// - Debug mode refreshes continuously, no time-out
// - Time-out at zero; option picks irq or reset
// - Interrupt response: request and set status bit
// - After interrupt, counter rolls to maximum
// - Reset response: device reset, status bit set
// - In STOP with reset option: recovery, set time-out and stop bits
// - By default watchdog runs during STOP
// - Unlock then 81H stops, 00H keeps running
// - Reload bytes written in order after unlock
// - Reload addresses read back live count
// - Status read clears upper four bits
module wdog_core
    import wdog_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Watchdog oscillator
    input wire logic rc_clk,
    output logic rc_osc_enable,
    // CPU core and system state
    input wire logic watchdog_refresh_instruction,
    input wire logic stop_mode,
    input wire logic on_chip_debugger,
    input wire logic ext_reset_event,
    // Time-out responses
    output logic irq_req,
    output logic sys_reset_req,
    output logic stop_recovery_req
);

    // ==========================================================
    // APB decode
    logic access;
    logic setup;
    logic wr_done;
    logic rd_done;
    logic hit_ctl;
    logic hit_upper;
    logic hit_high;
    logic hit_low;
    logic hit_opt;
    logic mapped;

    // Phase and address decoding
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_done = access & pwrite;
    assign rd_done = access & ~pwrite;
    assign hit_ctl = addr_hit(paddr, IDX_CTL);
    assign hit_upper = addr_hit(paddr, IDX_UPPER);
    assign hit_high = addr_hit(paddr, IDX_HIGH);
    assign hit_low = addr_hit(paddr, IDX_LOW);
    assign hit_opt = addr_hit(paddr, IDX_OPT);
    assign mapped = hit_ctl | hit_upper | hit_high | hit_low | hit_opt;

    // Zero wait states; error on unmapped address
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ==========================================================
    // Unlock sequencer and oscillator tick
    logic ld_upper;
    logic ld_high;
    logic ld_low;
    logic stop_off_q;
    logic tick;

    wdog_unlock u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .wr_any(wr_done),
        .wr_ctl(wr_done & hit_ctl),
        .wr_upper(wr_done & hit_upper),
        .wr_high(wr_done & hit_high),
        .wr_low(wr_done & hit_low),
        .wdata(pwdata[7:0]),
        .ld_upper(ld_upper),
        .ld_high(ld_high),
        .ld_low(ld_low),
        .stop_off_q(stop_off_q)
    );

    wdog_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .rc_clk(rc_clk),
        .tick(tick)
    );

    // ==========================================================
    // Option and reload registers
    logic opt_ao_q;
    logic opt_res_q;
    logic [23:0] reload_q;

    // Options written directly; reload bytes only when unlocked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_ao_q <= 1'b0;
            opt_res_q <= 1'b0;
            reload_q <= RELOAD_RST;
        end
        else
        begin
            if (wr_done && hit_opt)
            begin
                opt_ao_q <= pwdata[OPT_AO];
                opt_res_q <= pwdata[OPT_RES];
            end
            if (ld_upper)
                reload_q[23:16] <= pwdata[7:0];
            if (ld_high)
                reload_q[15:8] <= pwdata[7:0];
            if (ld_low)
                reload_q[7:0] <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Counter control
    logic enabled_q;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic run;
    logic first_en;
    logic refresh_ok;
    logic load;
    logic timeout;

    // Oscillator stops only in STOP after the disable code
    assign rc_osc_enable = ~(stop_mode & stop_off_q);
    assign run = enabled_q & rc_osc_enable;
    assign first_en = ~enabled_q
        & (watchdog_refresh_instruction | opt_ao_q);
    assign refresh_ok = watchdog_refresh_instruction & enabled_q
        & (cnt_q > REFRESH_FLOOR);
    assign load = first_en | refresh_ok
        | (enabled_q & on_chip_debugger);
    assign timeout = run & tick & ~load & (cnt_q == CNT_ONE);

    // Load wins; else one step per oscillator edge, 0 wraps to max
    always_comb
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = reload_q;
        else if (run && tick)
            cnt_d = cnt_q - CNT_ONE;
    end

    // Enable is sticky until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enabled_q <= 1'b0;
            cnt_q <= RELOAD_RST;
        end
        else
        begin
            enabled_q <= enabled_q | first_en;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================================
    // Time-out responses and status
    logic irq_q;
    logic rst_q;
    logic smr_q;
    logic [3:0] st_q;
    logic [3:0] st_d;
    logic rd_clr;

    // Upper four status bits; hardware set beats read clear
    assign rd_clr = rd_done & hit_ctl;
    assign st_d[ST_POR - ST_EXT] = st_q[ST_POR - ST_EXT]
        & ~rd_clr & ~timeout;
    assign st_d[ST_STOP - ST_EXT] = (timeout & opt_res_q & stop_mode)
        | (st_q[ST_STOP - ST_EXT] & ~rd_clr
        & ~(timeout & ~stop_mode));
    assign st_d[ST_WDT - ST_EXT] = timeout
        | (st_q[ST_WDT - ST_EXT] & ~rd_clr);
    assign st_d[0] = ext_reset_event | (st_q[0] & ~rd_clr);

    // One-cycle response pulses, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
            rst_q <= 1'b0;
            smr_q <= 1'b0;
            st_q <= 4'b1000;
        end
        else
        begin
            irq_q <= timeout & ~opt_res_q;
            rst_q <= timeout & opt_res_q & ~stop_mode;
            smr_q <= timeout & opt_res_q & stop_mode;
            st_q <= st_d;
        end
    end

    assign irq_req = irq_q;
    assign sys_reset_req = rst_q;
    assign stop_recovery_req = smr_q;

    // ==========================================================
    // Read data, captured in the setup phase
    logic [7:0] rd_byte;
    logic [31:0] prdata_q;

    // Reload addresses show the live count
    assign rd_byte = hit_ctl ? {st_q, 4'h0}
        : hit_upper ? cnt_q[23:16]
        : hit_high ? cnt_q[15:8]
        : hit_low ? cnt_q[7:0]
        : hit_opt ? {4'h0, enabled_q, stop_off_q, opt_res_q, opt_ao_q}
        : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup)
            prdata_q <= {24'h00_0000, rd_byte};
    end

    assign prdata = prdata_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_first_enable;
        !enabled_q ##1 enabled_q;
    endsequence

    sequence s_debug_hold;
        (enabled_q && on_chip_debugger)[*2];
    endsequence

    first_load_a: assert property (
        s_first_enable |-> cnt_q == $past(reload_q))
        else $error("first enable did not load reload");

    refresh_load_a: assert property (
        watchdog_refresh_instruction && enabled_q && cnt_q > REFRESH_FLOOR
        |=> cnt_q == $past(reload_q))
        else $error("refresh did not reload counter");

    refresh_floor_a: assert property (
        watchdog_refresh_instruction && enabled_q && !on_chip_debugger
        && cnt_q <= REFRESH_FLOOR && !(run && tick)
        |=> $stable(cnt_q))
        else $error("refresh at floor changed counter");

    debug_hold_a: assert property (
        s_debug_hold |-> !timeout && cnt_q == $past(reload_q))
        else $error("debug mode did not hold counter");

    count_step_a: assert property (
        enabled_q && !load && !(run && tick) |=> $stable(cnt_q))
        else $error("counter moved without oscillator edge");

    irq_resp_a: assert property (
        timeout && !opt_res_q
        |=> irq_req && st_q[ST_WDT - ST_EXT] && !sys_reset_req)
        else $error("interrupt time-out response wrong");

    rollover_a: assert property (
        run && tick && !load && cnt_q == CNT_ZERO
        |=> cnt_q == CNT_MAX)
        else $error("counter did not roll to maximum");

    reset_resp_a: assert property (
        timeout && opt_res_q && !stop_mode
        |=> sys_reset_req && !stop_recovery_req ##1 !sys_reset_req)
        else $error("reset time-out response wrong");

    stop_recov_a: assert property (
        timeout && opt_res_q && stop_mode
        |=> stop_recovery_req && st_q[ST_STOP - ST_EXT]
        && st_q[ST_WDT - ST_EXT])
        else $error("stop recovery response wrong");

    stop_freeze_a: assert property (
        stop_mode && stop_off_q && !load |=> $stable(cnt_q))
        else $error("counter ran in STOP while disabled");

    read_clear_a: assert property (
        rd_done && hit_ctl && !timeout && !ext_reset_event
        |=> st_q == 4'h0)
        else $error("status read did not clear");

endmodule

// *** tb/wdog_far_end.sv ***
// Oscillator, interrupt controller and reset logic beside the watchdog
module wdog_far_end #(
    parameter int RC_HALF_NS = 43
) (
    // System
    input wire logic pclk,
    input wire logic rc_osc_enable,
    // Time-out responses
    input wire logic irq_req,
    input wire logic sys_reset_req,
    input wire logic stop_recovery_req,
    // Oscillator and event tallies
    output logic rc_clk,
    output int irq_seen,
    output int rst_seen,
    output int rec_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Oscillator, stands low while disabled
    initial
    begin
        rc_clk = 1'b0;
        forever
        begin
            #(RC_HALF_NS);
            if (rc_osc_enable === 1'b1)
                rc_clk = ~rc_clk;
            else
                rc_clk = 1'b0;
        end
    end

    // ==========================================================
    // Tally of each response pulse; int counters start at zero
    always @(posedge pclk)
    begin
        if (irq_req === 1'b1)
            irq_seen <= irq_seen + 1;
        if (sys_reset_req === 1'b1)
            rst_seen <= rst_seen + 1;
        if (stop_recovery_req === 1'b1)
            rec_seen <= rec_seen + 1;
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the watchdog block
module tb_top
    import wdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, rc_clk, rc_osc_enable;
    logic watchdog_refresh_instruction, stop_mode, on_chip_debugger;
    logic ext_reset_event, irq_req, sys_reset_req, stop_recovery_req;
    int irq_seen, rst_seen, rec_seen;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ==========================================================
    // Design and its far side
    wdog_core dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rc_clk(rc_clk),
        .rc_osc_enable(rc_osc_enable),
        .watchdog_refresh_instruction(watchdog_refresh_instruction),
        .stop_mode(stop_mode), .on_chip_debugger(on_chip_debugger),
        .ext_reset_event(ext_reset_event), .irq_req(irq_req),
        .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req)
    );

    wdog_far_end far_u (
        .pclk(pclk), .rc_osc_enable(rc_osc_enable), .irq_req(irq_req),
        .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req),
        .rc_clk(rc_clk), .irq_seen(irq_seen), .rst_seen(rst_seen),
        .rec_seen(rec_seen)
    );

    // Hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, idx, d, v, e);
    endtask

    task automatic rd(input logic [11:0] idx, output logic [31:0] v);
        logic e;
        apb(1'b0, idx, 8'h00, v, e);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] idx,
                         input logic [31:0] exp);
        logic [31:0] v;
        rd(idx, v);
        chk(nm, exp, v);
    endtask

    task automatic kick;
        @(posedge pclk);
        watchdog_refresh_instruction <= 1'b1;
        @(posedge pclk);
        watchdog_refresh_instruction <= 1'b0;
    endtask

    task automatic unlock;
        wr(IDX_CTL, UNLOCK_1);
        wr(IDX_CTL, UNLOCK_2);
    endtask

    function automatic int tally(input int kind);
        return kind == 0 ? irq_seen : kind == 1 ? rst_seen : rec_seen;
    endfunction

    task automatic wait_evt(input int kind, input int lim, output int took);
        int base;
        base = tally(kind);
        took = 0;
        while (tally(kind) == base && took < lim)
        begin
            @(posedge pclk);
            took++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] v;
        logic e;
        repeat (100) @(posedge pclk);
        rdchk("ctl por", IDX_CTL, 8'h80);
        rdchk("ctl cleared", IDX_CTL, 8'h00);
        apb(1'b0, IDX_OPT, 8'h00, v, e);
        chk("opt reset", 8'h00, v);
        chk("mapped no err", 8'h00, e);
        chk("ready", 8'h01, pready);
        rdchk("idle upper", IDX_UPPER, 8'hFF);
        rdchk("idle low", IDX_LOW, 8'hFF);
        apb(1'b0, 12'h0FF8, 8'h00, v, e);
        chk("unmapped err", 8'h01, e);
        chk("unmapped data", 8'h00, v);
        ext_reset_event <= 1'b1;
        @(posedge pclk);
        ext_reset_event <= 1'b0;
        rdchk("ctl ext", IDX_CTL, 8'h10);
        chk("idle no irq", 8'h00, irq_seen);
        $display("reset test done");
    endtask

    task automatic t_reload;
        int took;
        unlock();
        wr(IDX_UPPER, 8'h00);
        wr(IDX_HIGH, 8'h00);
        wr(IDX_LOW, 8'h10);
        rdchk("ctl after unlock", IDX_CTL, 8'h00);
        kick();
        rdchk("opt enabled", IDX_OPT, 8'h08);
        rdchk("loaded upper", IDX_UPPER, 8'h00);
        wait_evt(0, 400, took);
        chk("irq period", 8'h01, took >= 230 && took <= 300);
        rdchk("ctl wdt", IDX_CTL, 8'h20);
        chk("no reset", 8'h00, rst_seen);
        repeat (40) @(posedge pclk);
        rdchk("rolled over", IDX_UPPER, 8'hFF);
        $display("reload test done");
    endtask

    task automatic t_floor;
        int took;
        int n;
        logic [31:0] v;
        kick();
        n = 0;
        do
        begin
            rd(IDX_LOW, v);
            n++;
        end
        while (v !== 32'h0000_0002 && n < 100);
        chk("reached floor", 8'h02, v);
        kick();
        wait_evt(0, 80, took);
        chk("refresh ignored", 8'h01, took < 80);
        $display("floor test done");
    endtask

    task automatic t_debug;
        int base;
        kick();
        base = irq_seen;
        on_chip_debugger <= 1'b1;
        repeat (400) @(posedge pclk);
        rdchk("debug count", IDX_LOW, 8'h10);
        chk("debug no irq", base, irq_seen);
        on_chip_debugger <= 1'b0;
        $display("debug test done");
    endtask

    task automatic t_relock;
        unlock();
        wr(IDX_OPT, 8'h00);
        wr(IDX_UPPER, 8'hFF);
        kick();
        rdchk("reload kept", IDX_UPPER, 8'h00);
        $display("relock test done");
    endtask

    task automatic t_reset_resp;
        int took;
        logic [31:0] v;
        wr(IDX_OPT, 8'h02);
        rd(IDX_CTL, v);
        kick();
        wait_evt(1, 400, took);
        chk("reset response", 8'h01, took < 400);
        rdchk("ctl wdt reset", IDX_CTL, 8'h20);
        // Let the count roll over so the refresh is taken
        repeat (20) @(posedge pclk);
        kick();
        stop_mode <= 1'b1;
        wait_evt(2, 400, took);
        chk("stop recovery", 8'h01, took < 400);
        rdchk("ctl stop wdt", IDX_CTL, 8'h60);
        stop_mode <= 1'b0;
        $display("reset response test done");
    endtask

    task automatic t_stop_off;
        int took;
        @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("osc default", 8'h01, rc_osc_enable);
        stop_mode <= 1'b0;
        unlock();
        wr(IDX_CTL, STOP_OFF_CODE);
        rdchk("opt stop off", IDX_OPT, 8'h0E);
        kick();
        stop_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("osc stopped", 8'h00, rc_osc_enable);
        wait_evt(2, 400, took);
        chk("frozen in stop", 8'h01, took == 400);
        stop_mode <= 1'b0;
        unlock();
        wr(IDX_CTL, STOP_ON_CODE);
        rdchk("opt stop on", IDX_OPT, 8'h0A);
        $display("stop test done");
    endtask

    task automatic t_always_on;
        logic [31:0] v;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(IDX_OPT, 8'h01);
        rdchk("opt always on", IDX_OPT, 8'h09);
        repeat (60) @(posedge pclk);
        rd(IDX_LOW, v);
        chk("always on counting", 8'h01, v[7:0] < 8'hFF);
        $display("always on test done");
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        watchdog_refresh_instruction = 1'b0;
        stop_mode = 1'b0;
        on_chip_debugger = 1'b0;
        ext_reset_event = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_reload();
        t_floor();
        t_debug();
        t_relock();
        t_reset_resp();
        t_stop_off();
        t_always_on();
        give_verdict();
    end
endmodule
